/* File: tb/dacc_capture_model.sv */
// partner: capture register clocked by the capture clock output
// assumes data_oe_n high means a floating pad, read here as unknown
`timescale 1ns/10ps
module dacc_capture_model
(
  input wire logic cap_clk,
  input wire logic oe_n,
  input wire logic [10:0] data,
  input wire logic ovr,
  output logic [10:0] word_a,
  output logic [10:0] word_b,
  output logic ovr_a
);
  // ****************
  // capture
  // ****************
  // channel a phase; small delay models the capture hold margin
  always @(posedge cap_clk)
  begin
    #1;
    word_a <= oe_n ? 11'hxxx : data;
    ovr_a <= oe_n ? 1'hx : ovr;
  end
  // channel b phase on the falling capture edge
  always @(negedge cap_clk)
  begin
    #1;
    word_b <= oe_n ? 11'hxxx : data;
  end
endmodule

/* File: tb/dacc_top_asserts.sv */
// checker: power, three-state, restorer and divider relations
// assumes it is bound onto dacc_top; one clock domain
`timescale 1ns/10ps
module dacc_top_asserts
(
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic SLEEP_REQUEST,
  input wire logic OUTPUT_THREE_STATE_PIN,
  input wire logic SLOW_CLOCK,
  input wire logic SAMPLE_EN,
  input wire logic INT_CLK_HIGH,
  input wire logic DUTY_RESTORED,
  input wire logic POWER_DOWN,
  input wire logic STANDBY,
  input wire logic REF_POWERED,
  input wire logic DATA_OE_N,
  input wire logic OVERRANGE_OE_N,
  input wire logic CAPTURE_CLOCK_OUTPUT,
  input wire logic CAPTURE_CLOCK_OE_N
);
  // ****************
  // properties
  // ****************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  AST_SLEEP_ENTER: assert property (SLEEP_REQUEST |=> POWER_DOWN)
    else $error("sleep pin did not enter power-down");
  AST_DOWN_FLOAT: assert property (POWER_DOWN && $past(POWER_DOWN) |->
    DATA_OE_N && OVERRANGE_OE_N && CAPTURE_CLOCK_OE_N)
    else $error("driver active in power-down");
  AST_PIN_FLOAT: assert property ($past(ARST_N) &&
    $past(OUTPUT_THREE_STATE_PIN) |-> DATA_OE_N && OVERRANGE_OE_N)
    else $error("three-state pin did not float outputs");
  AST_STBY_REF: assert property (STANDBY |-> REF_POWERED)
    else $error("reference off in standby");
  // lock flag is registered from the counter, so it drops two edges later
  AST_SLOW_UNLOCK: assert property ($past(ARST_N) &&
    $past(SLOW_CLOCK, 2) |-> !DUTY_RESTORED)
    else $error("restorer locked on slow clock");
  // unlocked: internal high time follows the raw once-per-period pulse
  AST_RAW_TIMING: assert property ($past(ARST_N) && !POWER_DOWN &&
    !$past(POWER_DOWN) && !DUTY_RESTORED && !$past(DUTY_RESTORED)
    |-> INT_CLK_HIGH == SAMPLE_EN)
    else $error("bypassed clock not raw");
  AST_DIVIDE_MAX: assert property (disable iff (!ARST_N || POWER_DOWN)
    SAMPLE_EN |-> ##[1:8] SAMPLE_EN)
    else $error("divided period longer than eight");
  AST_CAPCLK_TOGGLE: assert property ($past(ARST_N) |->
    CAPTURE_CLOCK_OUTPUT != $past(CAPTURE_CLOCK_OUTPUT))
    else $error("capture clock did not alternate");
  // main scenarios reached
  cover property (SLEEP_REQUEST ##1 POWER_DOWN);
  cover property (STANDBY);
  cover property ($rose(DUTY_RESTORED));
endmodule

bind dacc_top dacc_top_asserts chk_i
(
  .CLK(CLK), .ARST_N(ARST_N), .SLEEP_REQUEST(SLEEP_REQUEST),
  .OUTPUT_THREE_STATE_PIN(OUTPUT_THREE_STATE_PIN),
  .SLOW_CLOCK(SLOW_CLOCK), .SAMPLE_EN(SAMPLE_EN),
  .INT_CLK_HIGH(INT_CLK_HIGH), .DUTY_RESTORED(DUTY_RESTORED),
  .POWER_DOWN(POWER_DOWN), .STANDBY(STANDBY), .REF_POWERED(REF_POWERED),
  .DATA_OE_N(DATA_OE_N), .OVERRANGE_OE_N(OVERRANGE_OE_N),
  .CAPTURE_CLOCK_OUTPUT(CAPTURE_CLOCK_OUTPUT),
  .CAPTURE_CLOCK_OE_N(CAPTURE_CLOCK_OE_N)
);

/* File: tb/dual_adc_clock_and_output_control_tb.sv */
// bench: coding table, divider, restorer, strobe, power and outputs
// assumes a 20 MHz clock and the block's own register map
`timescale 1ns/10ps
module dual_adc_clock_and_output_control_tb;
  typedef struct packed
  {
    logic [1:0] cod;
    logic [12:0] raw;
    logic [10:0] code;
    logic ovr;
  } dacc_row_t;
  // coding, raw sample, expected word and flag
  localparam dacc_row_t ROWS [8] = '{
    '{2'h1, 13'h03ff, 11'h3ff, 1'h0}, '{2'h1, 13'h05dc, 11'h3ff, 1'h1},
    '{2'h1, 13'h1c00, 11'h400, 1'h0}, '{2'h1, 13'h1830, 11'h400, 1'h1},
    '{2'h0, 13'h0000, 11'h400, 1'h0}, '{2'h0, 13'h1c00, 11'h000, 1'h0},
    '{2'h0, 13'h03ff, 11'h7ff, 1'h0}, '{2'h2, 13'h0005, 11'h607, 1'h0}};
  logic clk, arst_n, we, stb_in, sleep, tsp, slow, sample_en, ich;
  logic restored, pdn, stby, refp, data_oe_n, ovr_out, ovr_a, cap_clk;
  logic [7:0] addr, wdata, rdata;
  logic [12:0] raw_a, raw_b;
  logic [10:0] data_out, word_a, word_b;
  int fails, checks_done, h, s;

  dacc_top #(.RAW_W(13)) uut
  (
    .CLK(clk), .ARST_N(arst_n), .REG_WE(we), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .ALIGN_STROBE(stb_in),
    .SLEEP_REQUEST(sleep), .OUTPUT_THREE_STATE_PIN(tsp),
    .SLOW_CLOCK(slow), .RAW_A(raw_a), .RAW_B(raw_b),
    .SAMPLE_EN(sample_en), .INT_CLK_HIGH(ich), .DUTY_RESTORED(restored),
    .POWER_DOWN(pdn), .STANDBY(stby), .REF_POWERED(refp),
    .DATA_OUT(data_out), .DATA_OE_N(data_oe_n), .OVERRANGE_OUT(ovr_out),
    .OVERRANGE_OE_N(), .CAPTURE_CLOCK_OUTPUT(cap_clk),
    .CAPTURE_CLOCK_OE_N()
  );
  dacc_capture_model cap_i
  (
    .cap_clk(cap_clk), .oe_n(data_oe_n), .data(data_out), .ovr(ovr_out),
    .word_a(word_a), .word_b(word_b), .ovr_a(ovr_a)
  );

  // ****************
  // helpers
  // ****************
  initial
  begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  task chk(input logic [10:0] got, input logic [10:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, got, exp);
    end
  endtask
  task complete_run;
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one-cycle write strobe, released on the next edge
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    we <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    we <= 1'h0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk) addr <= a;
    w(2);
    chk(11'(rdata), 11'(e));
  endtask
  // internal-high and sample-enable counts over n cycles
  task cnt(input int n);
    h = 0;
    s = 0;
    repeat (n)
    begin
      @(posedge clk);
      #1;
      h += ich;
      s += sample_en;
    end
  endtask
  // strobe, then look for the realigned pulse four edges on
  task stb(input logic hit);
    @(posedge clk) stb_in <= 1'h1;
    w(4);
    chk(11'(sample_en), 11'(hit));
    @(posedge clk) stb_in <= 1'h0;
  endtask
  // edges from a sample change until its word shows
  task lat(input logic [12:0] raw, input logic [10:0] code, input logic ov,
    input int n);
    int k;
    @(posedge clk) raw_a <= raw;
    k = 0;
    do
    begin
      @(posedge clk);
      #1;
      k++;
    end
    while (data_out !== code && k < 30);
    chk(11'(k), 11'(n));
    chk(11'(ovr_out), 11'(ov));
  endtask

  // ****************
  // watchdog
  // ****************
  initial
  begin
    repeat (6000) @(posedge clk);
    fails++;
    complete_run;
  end

  // ****************
  // main sequence
  // ****************
  initial
  begin
    {arst_n, we, stb_in, sleep, tsp, slow} = 6'h00;
    {addr, wdata, raw_a, raw_b} = 42'h0;
    repeat (4) @(posedge clk);
    arst_n <= 1'h1;
    rd(8'h09, 8'h01);
    rd(8'h14, 8'h01);
    rd(8'h3a, 8'h00);
    wr(8'h77, 8'hff);
    rd(8'h77, 8'h00);
    // restorer: ratio 4 then a rate change to 5
    wr(8'h0b, 8'h03);
    rd(8'h0b, 8'h03);
    w(40);
    cnt(20);
    chk(11'(h), 11'h00a);
    chk(11'(s), 11'h005);
    wr(8'h0b, 8'h04);
    w(2);
    chk(11'(restored), 11'h0);
    cnt(20);
    chk(11'(h), 11'h004);
    w(30);
    cnt(20);
    chk(11'(h), 11'h008);
    // strobe realignment at ratio 8
    wr(8'h0b, 8'h07);
    wr(8'h3a, 8'h02);
    stb(1'h1);
    stb(1'h1);
    wr(8'h3a, 8'h06);
    stb(1'h1);
    stb(1'h0);
    stb(1'h0);
    wr(8'h3a, 8'h00);
    wr(8'h0b, 8'h00);
    // coding table
    foreach (ROWS[i])
    begin
      wr(8'h14, {6'h00, ROWS[i].cod});
      @(posedge clk) raw_a <= ROWS[i].raw;
      w(20);
      chk(word_a, ROWS[i].code);
      chk(11'(ovr_a), 11'(ROWS[i].ovr));
    end
    // latency with channel b off, then shaper on a only
    wr(8'h14, 8'h01);
    wr(8'h05, 8'h02);
    wr(8'h14, 8'h11);
    wr(8'h05, 8'h03);
    @(posedge clk) raw_a <= 13'h05dc;
    w(20);
    lat(13'h0005, 11'h005, 1'h0, 10);
    w(3);
    chk(word_b, 11'h005);
    wr(8'h05, 8'h01);
    wr(8'h3c, 8'h01);
    wr(8'h05, 8'h03);
    w(20);
    lat(13'h05dc, 11'h3ff, 1'h1, 13);
    wr(8'h3c, 8'h00);
    wr(8'h14, 8'h01);
    @(posedge clk) raw_b <= 13'h0003;
    w(20);
    chk(word_b, 11'h003);
    wr(8'h14, 8'h11);
    w(2);
    chk(11'(data_oe_n), 11'h1);
    wr(8'h14, 8'h01);
    // power-down, standby, three-state pin, slow clock
    @(posedge clk) sleep <= 1'h1;
    w(3);
    chk(11'(pdn & data_oe_n), 11'h1);
    @(posedge clk) sleep <= 1'h0;
    w(3);
    chk(11'(pdn | data_oe_n), 11'h0);
    wr(8'h08, 8'h01);
    w(2);
    chk(11'(pdn & data_oe_n), 11'h1);
    wr(8'h08, 8'h02);
    w(2);
    chk(11'({pdn, stby, refp}), 11'h3);
    wr(8'h08, 8'h00);
    @(posedge clk) tsp <= 1'h1;
    w(2);
    chk(11'(data_oe_n), 11'h1);
    @(posedge clk) tsp <= 1'h0;
    w(2);
    chk(11'(data_oe_n), 11'h0);
    @(posedge clk) slow <= 1'h1;
    w(3);
    chk(11'(restored), 11'h0);
    @(posedge clk) slow <= 1'h0;
    w(35);
    chk(11'(restored), 11'h1);
    // restorer off, then a second reset brings it back
    wr(8'h09, 8'h00);
    w(2);
    chk(11'(restored), 11'h0);
    @(posedge clk) arst_n <= 1'h0;
    @(posedge clk) arst_n <= 1'h1;
    rd(8'h09, 8'h01);
    w(40);
    chk(11'(restored), 11'h1);
    complete_run;
  end
endmodule

/* File: verilog/dacc_pkg.sv */
// constants and carrier types of the dual converter clock and output control
// assumes one sample clock; a serial port front end decodes register access
package dacc_pkg;

  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] ADDR_CHAN_SEL = 8'h05; // per-channel write select
  localparam logic [7:0] ADDR_POWER = 8'h08; // power mode
  localparam logic [7:0] ADDR_DUTY = 8'h09; // duty restorer control
  localparam logic [7:0] ADDR_DIVIDE = 8'h0b; // divide ratio minus one
  localparam logic [7:0] ADDR_STATUS = 8'h0f; // read-only state
  localparam logic [7:0] ADDR_OUT_MODE = 8'h14; // output_mode_control
  localparam logic [7:0] ADDR_ALIGN = 8'h3a; // divider_align_control
  localparam logic [7:0] ADDR_SHAPER = 8'h3c; // noise shaper enable

  // ****************************************
  // field positions
  // ****************************************
  localparam int OUT_OFF_BIT = 4; // channel output disable
  localparam int ALIGN_EN_BIT = 1; // realign on strobe
  localparam int ALIGN_ONCE_BIT = 2; // only first strobe after write

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [1:0] CHAN_SEL_RST = 2'h3;
  localparam logic [1:0] POWER_RST = 2'h0;
  localparam logic DUTY_EN_RST = 1'b1; // restorer on from power-up
  localparam logic [2:0] DIVIDE_RST = 3'h0;
  localparam logic [7:0] ALIGN_RST = 8'h00;

  // ****************************************
  // timing counts
  // ****************************************
  localparam int CLK_MHZ = 20;
  localparam int RELOCK_MIN_NS = 1500; // least relock wait
  localparam int RELOCK_CYC = (RELOCK_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int LAT_PLAIN = 10; // pipeline latency, shaper off
  localparam int LAT_SHAPED = 13; // pipeline latency, shaper on

  // ****************************************
  // enumerations and carriers
  // ****************************************
  typedef enum logic [1:0]
  {
    CODE_OFFSET = 2'h0,
    CODE_TWOS = 2'h1,
    CODE_GRAY = 2'h2
  } dacc_coding_t;

  typedef enum logic [1:0]
  {
    PWR_RUN = 2'h0,
    PWR_DOWN = 2'h1,
    PWR_STANDBY = 2'h2
  } dacc_power_t;

  localparam logic [1:0] CODING_RST = 2'h1; // two's complement default

  // per-channel configuration
  typedef struct packed
  {
    logic [1:0] coding;
    logic out_off;
    logic shaper_on;
  } dacc_chan_cfg_t;

  // one pipelined sample
  typedef struct packed
  {
    logic valid;
    logic ovr;
    logic [10:0] code;
  } dacc_sample_t;

endpackage

/* File: verilog/dacc_top.sv */
// dual converter digital control: divider, duty restorer, power, outputs
// assumes register writes arrive already decoded from the serial port,
// raw samples arrive signed, and pad logic resolves the output enables
`timescale 1ns/10ps

module dacc_top
#(
  parameter int RAW_W = 13 // raw sample width, wider than the code
)
(
  input wire logic CLK,
  input wire logic ARST_N,
  input wire logic REG_WE,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  input wire logic ALIGN_STROBE,
  input wire logic SLEEP_REQUEST,
  input wire logic OUTPUT_THREE_STATE_PIN,
  input wire logic SLOW_CLOCK,
  input wire logic signed [RAW_W-1:0] RAW_A,
  input wire logic signed [RAW_W-1:0] RAW_B,
  output logic SAMPLE_EN,
  output logic INT_CLK_HIGH,
  output logic DUTY_RESTORED,
  output logic POWER_DOWN,
  output logic STANDBY,
  output logic REF_POWERED,
  output logic [10:0] DATA_OUT,
  output logic DATA_OE_N,
  output logic OVERRANGE_OUT,
  output logic OVERRANGE_OE_N,
  output logic CAPTURE_CLOCK_OUTPUT,
  output logic CAPTURE_CLOCK_OE_N
);

  // ****************************************
  // registers
  // ****************************************
  localparam int LAT_MAX = dacc_pkg::LAT_SHAPED - 1;
  localparam int TAP_PLAIN = dacc_pkg::LAT_PLAIN - 2;
  localparam int TAP_SHAPED = dacc_pkg::LAT_SHAPED - 2;
  localparam logic signed [RAW_W-1:0] LIM_HI = RAW_W'(1023);
  localparam logic signed [RAW_W-1:0] LIM_LO = -RAW_W'(1024);

  logic [1:0] chan_sel_reg; // which channels a write reaches
  logic [1:0] power_reg; // power mode field
  logic duty_en_reg; // duty restorer enable
  logic [2:0] divide_reg; // ratio minus one
  logic [7:0] align_reg; // divider_align_control
  dacc_pkg::dacc_chan_cfg_t cfg_reg [2]; // per-channel setup
  logic [7:0] rdata_next;

  // ****************************************
  // register writes
  // ****************************************
  // plain storage; side effects are handled by their own processes
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      chan_sel_reg <= dacc_pkg::CHAN_SEL_RST;
      power_reg <= dacc_pkg::POWER_RST;
      duty_en_reg <= dacc_pkg::DUTY_EN_RST;
      divide_reg <= dacc_pkg::DIVIDE_RST;
      align_reg <= dacc_pkg::ALIGN_RST;
      for (int c = 0; c < 2; c++)
      begin
        cfg_reg[c] <= '{dacc_pkg::CODING_RST, 1'b0, 1'b0};
      end
    end
    else if (REG_WE)
    begin
      unique case (REG_ADDR)
        dacc_pkg::ADDR_CHAN_SEL: chan_sel_reg <= REG_WDATA[1:0];
        dacc_pkg::ADDR_POWER: power_reg <= REG_WDATA[1:0];
        dacc_pkg::ADDR_DUTY: duty_en_reg <= REG_WDATA[0];
        dacc_pkg::ADDR_DIVIDE: divide_reg <= REG_WDATA[2:0];
        dacc_pkg::ADDR_ALIGN: align_reg <= REG_WDATA;
        dacc_pkg::ADDR_OUT_MODE:
        begin
          // only the selected channels take the write
          for (int c = 0; c < 2; c++)
          begin
            if (chan_sel_reg[c])
            begin
              cfg_reg[c].coding <= REG_WDATA[1:0];
              cfg_reg[c].out_off <= REG_WDATA[dacc_pkg::OUT_OFF_BIT];
            end
          end
        end
        dacc_pkg::ADDR_SHAPER:
        begin
          for (int c = 0; c < 2; c++)
          begin
            if (chan_sel_reg[c])
            begin
              cfg_reg[c].shaper_on <= REG_WDATA[0];
            end
          end
        end
        default:
        begin
          // unmapped writes are dropped
        end
      endcase
    end
  end

  // ****************************************
  // strobe resynchroniser and realign logic
  // ****************************************
  logic sync1_reg; // first stage, read only by the second
  logic sync2_reg;
  logic sync3_reg; // edge history
  logic armed_reg; // one-shot realign armed
  logic strobe_edge;
  logic align_accept;

  // two flops before the strobe is looked at
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= ALIGN_STROBE;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  assign strobe_edge = sync2_reg && !sync3_reg;
  // every strobe, or only the first after the control write
  assign align_accept = strobe_edge && align_reg[dacc_pkg::ALIGN_EN_BIT] &&
    (!align_reg[dacc_pkg::ALIGN_ONCE_BIT] || armed_reg);

  // arming by a write wins over the clear by an accepted strobe
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      armed_reg <= 1'b0;
    end
    else if (REG_WE && REG_ADDR == dacc_pkg::ADDR_ALIGN)
    begin
      armed_reg <= 1'b1;
    end
    else if (align_accept)
    begin
      armed_reg <= 1'b0;
    end
  end

  // ****************************************
  // clock divider
  // ****************************************
  logic [2:0] div_cnt_reg; // zero is the initial state
  logic [2:0] half_cnt; // restored high time in input cycles

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      div_cnt_reg <= 3'h0;
    end
    else if (align_accept)
    begin
      div_cnt_reg <= 3'h0;
    end
    else if (div_cnt_reg >= divide_reg)
    begin
      div_cnt_reg <= 3'h0;
    end
    else
    begin
      div_cnt_reg <= div_cnt_reg + 3'h1;
    end
  end

  // odd ratios round the high time down; ratio one stays high
  assign half_cnt = (divide_reg == 3'h0) ? 3'h1 :
    3'((4'({1'b0, divide_reg}) + 4'h1) >> 1);

  // ****************************************
  // duty restorer lock tracking
  // ****************************************
  logic [7:0] lock_cnt_reg; // cycles since last clear by rate change, slow clock or restorer off; holds at lock
  logic locked;
  logic rate_change;

  // a ratio write with a new value changes the internal rate and costs a relock
  assign rate_change = REG_WE && REG_ADDR == dacc_pkg::ADDR_DIVIDE &&
    REG_WDATA[2:0] != divide_reg;

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      lock_cnt_reg <= 8'h00;
    end
    else if (!duty_en_reg || SLOW_CLOCK || rate_change)
    begin
      lock_cnt_reg <= 8'h00;
    end
    else if (!locked)
    begin
      lock_cnt_reg <= lock_cnt_reg + 8'h01;
    end
  end

  assign locked = lock_cnt_reg >= 8'(dacc_pkg::RELOCK_CYC);

  // internal clock level: restored half duty, or raw one-cycle pulse
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      INT_CLK_HIGH <= 1'b0;
      DUTY_RESTORED <= 1'b0;
      SAMPLE_EN <= 1'b0;
    end
    else
    begin
      SAMPLE_EN <= div_cnt_reg == 3'h0;
      DUTY_RESTORED <= duty_en_reg && locked;
      if (duty_en_reg && locked)
      begin
        INT_CLK_HIGH <= div_cnt_reg < half_cnt;
      end
      else
      begin
        INT_CLK_HIGH <= div_cnt_reg == 3'h0;
      end
    end
  end

  // ****************************************
  // power modes
  // ****************************************
  logic pdown;

  // pin high or register sets sleep; pin low with register clear runs
  assign pdown = SLEEP_REQUEST || power_reg == dacc_pkg::PWR_DOWN;

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      POWER_DOWN <= 1'b0;
      STANDBY <= 1'b0;
      REF_POWERED <= 1'b1;
    end
    else
    begin
      POWER_DOWN <= pdown;
      STANDBY <= !pdown && power_reg == dacc_pkg::PWR_STANDBY;
      REF_POWERED <= !pdown;
    end
  end

  // ****************************************
  // sample pipeline
  // ****************************************
  dacc_pkg::dacc_sample_t pipe_reg [2][LAT_MAX];
  dacc_pkg::dacc_sample_t first [2];
  logic signed [RAW_W-1:0] raw [2];

  assign raw[0] = RAW_A;
  assign raw[1] = RAW_B;

  // clip beyond the span; exact limits are in range
  always_comb
  begin
    for (int c = 0; c < 2; c++)
    begin
      first[c].valid = div_cnt_reg == 3'h0;
      first[c].ovr = raw[c] > LIM_HI || raw[c] < LIM_LO;
      if (raw[c] > LIM_HI)
      begin
        first[c].code = 11'h3ff;
      end
      else if (raw[c] < LIM_LO)
      begin
        first[c].code = 11'h400;
      end
      else
      begin
        first[c].code = raw[c][10:0];
      end
    end
  end

  // fixed-length shift; the tap picks the latency
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      for (int c = 0; c < 2; c++)
      begin
        for (int s = 0; s < LAT_MAX; s++)
        begin
          pipe_reg[c][s] <= '0;
        end
      end
    end
    else
    begin
      for (int c = 0; c < 2; c++)
      begin
        pipe_reg[c][0] <= first[c];
        for (int s = 1; s < LAT_MAX; s++)
        begin
          pipe_reg[c][s] <= pipe_reg[c][s-1];
        end
      end
    end
  end

  // ****************************************
  // output coding and interleave
  // ****************************************
  dacc_pkg::dacc_sample_t held_reg [2]; // last word per channel
  dacc_pkg::dacc_sample_t held_next [2];
  dacc_pkg::dacc_sample_t tap [2];
  logic phase_reg; // high is the rising output phase
  logic [10:0] ob;
  logic use_chan; // channel that feeds the next word

  // tap at latency minus two: one edge into stage zero, one out
  always_comb
  begin
    ob = 11'h000;
    for (int c = 0; c < 2; c++)
    begin
      tap[c] = cfg_reg[c].shaper_on ? pipe_reg[c][TAP_SHAPED] :
        pipe_reg[c][TAP_PLAIN];
      held_next[c] = held_reg[c];
      if (tap[c].valid)
      begin
        ob = {~tap[c].code[10], tap[c].code[9:0]};
        held_next[c].ovr = tap[c].ovr;
        held_next[c].valid = 1'b1;
        unique case (cfg_reg[c].coding)
          dacc_pkg::CODE_OFFSET: held_next[c].code = ob;
          dacc_pkg::CODE_GRAY: held_next[c].code = ob ^ (ob >> 1);
          default: held_next[c].code = tap[c].code;
        endcase
      end
    end
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      held_reg[0] <= '0;
      held_reg[1] <= '0;
      phase_reg <= 1'b0;
    end
    else
    begin
      held_reg <= held_next;
      phase_reg <= !phase_reg;
    end
  end

  // a lone enabled channel fills both phases
  always_comb
  begin
    if (cfg_reg[1].out_off)
    begin
      use_chan = 1'b0;
    end
    else if (cfg_reg[0].out_off)
    begin
      use_chan = 1'b1;
    end
    else
    begin
      use_chan = phase_reg; // next phase is falling
    end
  end

  // word and flag leave together from the same flops
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      DATA_OUT <= 11'h000;
      OVERRANGE_OUT <= 1'b0;
      CAPTURE_CLOCK_OUTPUT <= 1'b0;
    end
    else
    begin
      DATA_OUT <= held_next[use_chan].code;
      OVERRANGE_OUT <= held_next[use_chan].ovr;
      CAPTURE_CLOCK_OUTPUT <= !phase_reg;
    end
  end

  // ****************************************
  // driver enables
  // ****************************************
  // slow path: the pin is not meant for bus sharing
  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      DATA_OE_N <= 1'b1;
      OVERRANGE_OE_N <= 1'b1;
      CAPTURE_CLOCK_OE_N <= 1'b1;
    end
    else
    begin
      DATA_OE_N <= pdown || OUTPUT_THREE_STATE_PIN ||
        (cfg_reg[0].out_off && cfg_reg[1].out_off);
      OVERRANGE_OE_N <= pdown || OUTPUT_THREE_STATE_PIN;
      CAPTURE_CLOCK_OE_N <= pdown;
    end
  end

  // ****************************************
  // register reads
  // ****************************************
  // per-channel reads show channel a unless only b is selected
  always_comb
  begin
    rdata_next = 8'h00;
    unique case (REG_ADDR)
      dacc_pkg::ADDR_CHAN_SEL: rdata_next = {6'h00, chan_sel_reg};
      dacc_pkg::ADDR_POWER: rdata_next = {6'h00, power_reg};
      dacc_pkg::ADDR_DUTY: rdata_next = {7'h00, duty_en_reg};
      dacc_pkg::ADDR_DIVIDE: rdata_next = {5'h00, divide_reg};
      dacc_pkg::ADDR_ALIGN: rdata_next = align_reg;
      dacc_pkg::ADDR_STATUS:
        rdata_next = {1'b0, armed_reg, pdown, DUTY_RESTORED, 1'b0,
          div_cnt_reg};
      dacc_pkg::ADDR_OUT_MODE:
        rdata_next = {3'h0, cfg_reg[chan_sel_reg == 2'h2].out_off, 2'h0,
          cfg_reg[chan_sel_reg == 2'h2].coding};
      dacc_pkg::ADDR_SHAPER:
        rdata_next = {7'h00, cfg_reg[chan_sel_reg == 2'h2].shaper_on};
      default: rdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      REG_RDATA <= 8'h00;
    end
    else
    begin
      REG_RDATA <= rdata_next;
    end
  end

endmodule
